/* verilog/mpio_ports.sv */
// Top: pin multiplexing and APB registers for the 3-bit, input-only and 5-bit ports
`timescale 1ns/100ps
`default_nettype none
module mpio_ports
  import mpio_pkg::*;
(
  input  wire logic                 CORE_CLK,
  input  wire logic                 RESET_N,
  input  wire logic                 HW_STANDBY,
  input  wire logic                 SW_STANDBY,
  input  wire logic                 PSEL,
  input  wire logic                 PENABLE,
  input  wire logic                 PWRITE,
  input  wire logic [15:0]          PADDR,
  input  wire logic [31:0]          PWDATA,
  input  wire logic [3:0]           PSTRB,
  output var  logic [31:0]          PRDATA,
  output logic                      PREADY,
  output logic                      PSLVERR,
  input  wire logic [MPIO_P6_W-1:0] P6_PIN_IN,
  output var  logic [MPIO_P6_W-1:0] P6_PIN_OUT,
  output var  logic [MPIO_P6_W-1:0] P6_PIN_OE,
  input  wire logic [MPIO_P7_W-1:0] P7_PIN_IN,
  input  wire logic [MPIO_P8_W-1:0] P8_PIN_IN,
  output var  logic [MPIO_P8_W-1:0] P8_PIN_OUT,
  output var  logic [MPIO_P8_W-1:0] P8_PIN_OE,
  input  wire logic                 BUS_ACK_N,
  output var  logic                 BUS_REQUEST_IN_N,
  output var  logic                 WAIT_IN_N,
  input  wire logic [3:0]           CHIP_SELECT_N,
  input  wire logic                 REFRESH_STROBE_N,
  input  wire logic                 REFRESH_ENABLE,
  output var  logic [3:0]           EXT_INTERRUPT_N
);

  // ==========================================================
  // Registers and synchronised pins
  logic [7:0]           p6_dir_reg;
  logic [7:0]           p6_data_reg;
  logic [7:0]           port8_direction_reg;
  logic [7:0]           port8_output_latch_reg;
  logic [7:0]           bus_release_control_reg;
  logic [7:0]           wait_control_reg;
  logic [MPIO_P6_W-1:0] p6_pin_s;
  logic [MPIO_P7_W-1:0] p7_pin_s;
  logic [MPIO_P8_W-1:0] p8_pin_s;
  logic                 wr_en;
  logic                 rd_en;
  logic                 addr_hit;
  logic                 bus_release_enable;
  logic                 wait_pin_sel;
  logic [7:0]           p6_read;
  logic [7:0]           p8_read;
  logic [7:0]           rd_byte;

  // ==========================================================
  // Helpers
  function automatic logic [7:0] mix_read(input logic [7:0] dir, input logic [7:0] latch,
                                          input logic [7:0] pins);
    mix_read = (dir & latch) | (~dir & pins);
  endfunction

  function automatic logic [7:0] wdata_byte(input logic [31:0] wd);
    wdata_byte = wd[7:0];
  endfunction

  // ==========================================================
  // Pin synchronisers
  mpio_sync #(.W(MPIO_P6_W)) u_sync_p6 (
    .clk   (CORE_CLK),
    .rst_n (RESET_N),
    .d     (P6_PIN_IN),
    .q     (p6_pin_s)
  );

  mpio_sync #(.W(MPIO_P7_W)) u_sync_p7 (
    .clk   (CORE_CLK),
    .rst_n (RESET_N),
    .d     (P7_PIN_IN),
    .q     (p7_pin_s)
  );

  mpio_sync #(.W(MPIO_P8_W)) u_sync_p8 (
    .clk   (CORE_CLK),
    .rst_n (RESET_N),
    .d     (P8_PIN_IN),
    .q     (p8_pin_s)
  );

  // ==========================================================
  // APB decode
  always_comb begin
    case (PADDR)
      MPIO_P6_DIR_ADDR,
      MPIO_P6_DATA_ADDR,
      MPIO_P8_DIR_ADDR,
      MPIO_P7_LEVEL_ADDR,
      MPIO_P8_DATA_ADDR,
      MPIO_BUS_CTRL_ADDR,
      MPIO_WAIT_CTRL_ADDR: addr_hit = 1'b1;
      default:             addr_hit = 1'b0;
    endcase
  end

  assign PREADY  = 1'b1;
  assign PSLVERR = PSEL & PENABLE & ~addr_hit;
  assign wr_en   = PSEL & PENABLE & PWRITE & addr_hit & PSTRB[0];
  assign rd_en   = PSEL & ~PENABLE & ~PWRITE;

  // ==========================================================
  // 3-bit port registers
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      p6_dir_reg  <= MPIO_P6_DIR_RST;
      p6_data_reg <= MPIO_P6_DATA_RST;
    end else if (HW_STANDBY) begin
      p6_dir_reg  <= MPIO_P6_DIR_RST;
      p6_data_reg <= MPIO_P6_DATA_RST;
    end else if (wr_en && PADDR == MPIO_P6_DIR_ADDR) begin
      p6_dir_reg  <= wdata_byte(PWDATA) | MPIO_P6_RSV;
    end else if (wr_en && PADDR == MPIO_P6_DATA_ADDR) begin
      p6_data_reg <= wdata_byte(PWDATA) | MPIO_P6_RSV;
    end
  end

  // ==========================================================
  // Bus-release and wait control
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      bus_release_control_reg <= MPIO_BUS_CTRL_RST;
      wait_control_reg        <= MPIO_WAIT_CTRL_RST;
    end else if (HW_STANDBY) begin
      bus_release_control_reg <= MPIO_BUS_CTRL_RST;
      wait_control_reg        <= MPIO_WAIT_CTRL_RST;
    end else if (wr_en && PADDR == MPIO_BUS_CTRL_ADDR) begin
      bus_release_control_reg <= wdata_byte(PWDATA);
    end else if (wr_en && PADDR == MPIO_WAIT_CTRL_ADDR) begin
      wait_control_reg        <= wdata_byte(PWDATA);
    end
  end

  // ==========================================================
  // 5-bit port registers
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      port8_direction_reg <= MPIO_P8_DIR_RST;
    end else if (HW_STANDBY) begin
      port8_direction_reg <= MPIO_P8_DIR_RST;
    end else if (wr_en && PADDR == MPIO_P8_DIR_ADDR) begin
      port8_direction_reg <= wdata_byte(PWDATA);
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      port8_output_latch_reg <= MPIO_P8_DATA_RST;
    end else if (HW_STANDBY) begin
      port8_output_latch_reg <= MPIO_P8_DATA_RST;
    end else if (wr_en && PADDR == MPIO_P8_DATA_ADDR) begin
      port8_output_latch_reg <= wdata_byte(PWDATA) | MPIO_P8_RSV;
    end
  end

  // ==========================================================
  // Pin function selection
  assign bus_release_enable = bus_release_control_reg[MPIO_BUS_RELEASE_ENABLE_BIT];
  assign wait_pin_sel = (&wait_control_reg[MPIO_WAIT_EN_LSB +: MPIO_WAIT_EN_W])
                        & wait_control_reg[MPIO_WMS_HI_BIT];

  // Outputs registered: a change lands one edge after the write
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      P6_PIN_OUT <= '0;
      P6_PIN_OE  <= '0;
    end else begin
      if (bus_release_enable) begin
        P6_PIN_OUT[MPIO_P6_BACK_BIT] <= BUS_ACK_N;
        P6_PIN_OE[MPIO_P6_BACK_BIT]  <= 1'b1;
        P6_PIN_OUT[MPIO_P6_BUS_REQUEST_IN_BIT] <= 1'b0;
        P6_PIN_OE[MPIO_P6_BUS_REQUEST_IN_BIT]  <= 1'b0;
      end else begin
        P6_PIN_OUT[MPIO_P6_BACK_BIT] <= p6_data_reg[MPIO_P6_BACK_BIT];
        P6_PIN_OE[MPIO_P6_BACK_BIT]  <= p6_dir_reg[MPIO_P6_BACK_BIT];
        P6_PIN_OUT[MPIO_P6_BUS_REQUEST_IN_BIT] <= p6_data_reg[MPIO_P6_BUS_REQUEST_IN_BIT];
        P6_PIN_OE[MPIO_P6_BUS_REQUEST_IN_BIT]  <= p6_dir_reg[MPIO_P6_BUS_REQUEST_IN_BIT];
      end
      if (wait_pin_sel) begin
        P6_PIN_OUT[MPIO_P6_WAIT_BIT] <= 1'b0;
        P6_PIN_OE[MPIO_P6_WAIT_BIT]  <= 1'b0;
      end else begin
        P6_PIN_OUT[MPIO_P6_WAIT_BIT] <= p6_data_reg[MPIO_P6_WAIT_BIT];
        P6_PIN_OE[MPIO_P6_WAIT_BIT]  <= p6_dir_reg[MPIO_P6_WAIT_BIT];
      end
    end
  end

  // Bus-control inputs taken from the pins
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      BUS_REQUEST_IN_N <= 1'b1;
      WAIT_IN_N        <= 1'b1;
    end else begin
      BUS_REQUEST_IN_N <= bus_release_enable ? p6_pin_s[MPIO_P6_BUS_REQUEST_IN_BIT] : 1'b1;
      WAIT_IN_N        <= wait_pin_sel ? p6_pin_s[MPIO_P6_WAIT_BIT] : 1'b1;
    end
  end

  // 5-bit port drive; software standby holds the registers so the pins keep state
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      P8_PIN_OUT <= '1;
      P8_PIN_OE  <= '0;
    end else if (!SW_STANDBY) begin
      for (int i = 1; i < MPIO_P8_W; i++) begin
        P8_PIN_OUT[i] <= CHIP_SELECT_N[MPIO_P8_W-1-i];
        P8_PIN_OE[i]  <= port8_direction_reg[i];
      end
      if (REFRESH_ENABLE) begin
        P8_PIN_OUT[MPIO_P8_GEN_BIT] <= REFRESH_STROBE_N;
        P8_PIN_OE[MPIO_P8_GEN_BIT]  <= 1'b1;
      end else begin
        P8_PIN_OUT[MPIO_P8_GEN_BIT] <= port8_output_latch_reg[MPIO_P8_GEN_BIT];
        P8_PIN_OE[MPIO_P8_GEN_BIT]  <= port8_direction_reg[MPIO_P8_GEN_BIT];
      end
    end
  end

  // Interrupt inputs are always fed from pins 3..0
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      EXT_INTERRUPT_N <= '1;
    end else begin
      EXT_INTERRUPT_N <= p8_pin_s[3:0];
    end
  end

  // ==========================================================
  // Read mux
  always_comb begin
    p6_read = mix_read(p6_dir_reg, p6_data_reg, {5'h00, p6_pin_s}) | MPIO_P6_RSV;
    p8_read = mix_read(port8_direction_reg, port8_output_latch_reg,
                       {3'h0, p8_pin_s}) | MPIO_P8_RSV;
    case (PADDR)
      MPIO_P6_DIR_ADDR:    rd_byte = MPIO_ALL_ONES;
      MPIO_P6_DATA_ADDR:   rd_byte = p6_read;
      MPIO_P8_DIR_ADDR:    rd_byte = MPIO_ALL_ONES;
      MPIO_P7_LEVEL_ADDR:  rd_byte = p7_pin_s;
      MPIO_P8_DATA_ADDR:   rd_byte = p8_read;
      MPIO_BUS_CTRL_ADDR:  rd_byte = bus_release_control_reg;
      MPIO_WAIT_CTRL_ADDR: rd_byte = wait_control_reg;
      default:             rd_byte = 8'h00;
    endcase
  end

  // Read data captured in setup phase, stable through access
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      PRDATA <= MPIO_ZERO32;
    end else if (rd_en) begin
      PRDATA <= {24'h000000, rd_byte};
    end
  end

endmodule
`default_nettype wire

/* verilog/mpio_pkg.sv */
// Package: register map, reset values and field positions for the multiplexed ports
package mpio_pkg;

  // ==========================================================
  // Register byte addresses (low 16 bits)
  localparam logic [15:0] MPIO_P6_DIR_ADDR   = 16'hFFC9;
  localparam logic [15:0] MPIO_P6_DATA_ADDR  = 16'hFFCB;
  localparam logic [15:0] MPIO_P8_DIR_ADDR   = 16'hFFCD;
  localparam logic [15:0] MPIO_P7_LEVEL_ADDR = 16'hFFCE;
  localparam logic [15:0] MPIO_P8_DATA_ADDR  = 16'hFFCF;
  localparam logic [15:0] MPIO_BUS_CTRL_ADDR = 16'hFFD8;
  localparam logic [15:0] MPIO_WAIT_CTRL_ADDR = 16'hFFD9;

  // ==========================================================
  // Widths
  localparam int MPIO_P6_W = 3;
  localparam int MPIO_P7_W = 8;
  localparam int MPIO_P8_W = 5;

  // ==========================================================
  // Reset values
  localparam logic [7:0] MPIO_P6_DIR_RST  = 8'h80;
  localparam logic [7:0] MPIO_P6_DATA_RST = 8'h80;
  localparam logic [7:0] MPIO_P8_DIR_RST  = 8'hF0;
  localparam logic [7:0] MPIO_P8_DATA_RST = 8'hE0;
  localparam logic [7:0] MPIO_BUS_CTRL_RST = 8'h00;
  localparam logic [7:0] MPIO_WAIT_CTRL_RST = 8'h00;

  // ==========================================================
  // Fixed read patterns
  localparam logic [7:0]  MPIO_ALL_ONES   = 8'hFF;
  localparam logic [7:0]  MPIO_P8_RSV     = 8'hE0;
  localparam logic [7:0]  MPIO_P6_RSV     = 8'h80;
  localparam logic [31:0] MPIO_ZERO32     = 32'h00000000;

  // ==========================================================
  // Field positions
  localparam int MPIO_BUS_RELEASE_ENABLE_BIT     = 0;
  localparam int MPIO_WAIT_EN_LSB  = 0;
  localparam int MPIO_WAIT_EN_W    = 4;
  localparam int MPIO_WMS_HI_BIT   = 4;
  localparam int MPIO_P6_BACK_BIT  = 2;
  localparam int MPIO_P6_BUS_REQUEST_IN_BIT  = 1;
  localparam int MPIO_P6_WAIT_BIT  = 0;
  localparam int MPIO_P8_GEN_BIT   = 0;

endpackage

/* verilog/mpio_sync.sv */
// Three-stage pin input synchroniser with agreement filter
`timescale 1ns/100ps
`default_nettype none
module mpio_sync #(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);

  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;

  // ==========================================================
  // Synchroniser chain
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      // Idle high so active-low inputs see no false level after reset
      s1_reg <= '1;
      s2_reg <= '1;
      s3_reg <= '1;
    end else begin
      s1_reg <= d;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // ==========================================================
  // Accept a bit once stages two and three agree
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '1;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (s2_reg[i] == s3_reg[i]) begin
          q[i] <= s3_reg[i];
        end
      end
    end
  end

endmodule
`default_nettype wire

/* testbench/mpio_ports_asserts.sv */
// Checker: port-level properties of the multiplexed ports
`timescale 1ns/100ps
`default_nettype none
module mpio_ports_chk
  import mpio_pkg::*;
(
  input wire logic                 CORE_CLK,
  input wire logic                 RESET_N,
  input wire logic                 HW_STANDBY,
  input wire logic                 SW_STANDBY,
  input wire logic                 PSEL,
  input wire logic                 PENABLE,
  input wire logic                 PWRITE,
  input wire logic [15:0]          PADDR,
  input wire logic [31:0]          PRDATA,
  input wire logic                 PSLVERR,
  input wire logic [MPIO_P6_W-1:0] P6_PIN_OE,
  input wire logic [MPIO_P7_W-1:0] P7_PIN_IN,
  input wire logic [MPIO_P8_W-1:0] P8_PIN_OUT,
  input wire logic [MPIO_P8_W-1:0] P8_PIN_OE,
  input wire logic                 BUS_REQUEST_IN_N,
  input wire logic                 WAIT_IN_N,
  input wire logic [3:0]           CHIP_SELECT_N
);
  // ==========================================================
  // Read setup and input pin age
  logic       rd_su;
  logic [7:0] p7_prev_reg;
  logic [2:0] p7_age_reg;
  assign rd_su = PSEL && !PENABLE && !PWRITE;
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      p7_prev_reg <= 8'h00;
      p7_age_reg  <= 3'h0;
    end else begin
      p7_prev_reg <= P7_PIN_IN;
      p7_age_reg  <= (P7_PIN_IN != p7_prev_reg) ? 3'h0 : p7_age_reg + {2'h0, p7_age_reg != 3'h7};
    end
  end
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RESET_N);
  // ==========================================================
  // Properties
  a_dir_reads_ones: assert property (rd_su && PADDR == MPIO_P8_DIR_ADDR |=> PRDATA == 32'h000000FF)
    else $error("direction read not all ones");
  a_p8_rsv_ones: assert property (rd_su && PADDR == MPIO_P8_DATA_ADDR |=> PRDATA[31:5] == 27'h0000007)
    else $error("reserved data bits wrong");
  a_p7_live_read: assert property (rd_su && PADDR == MPIO_P7_LEVEL_ADDR && p7_age_reg >= 3'h6
    |=> PRDATA == {24'h000000, $past(P7_PIN_IN)}) else $error("input port read not pin level");
  a_unmapped_err: assert property (PSEL && PENABLE |-> PSLVERR == !(PADDR inside {16'hFFC9, 16'hFFCB,
    16'hFFCD, 16'hFFCE, 16'hFFCF, 16'hFFD8, 16'hFFD9})) else $error("error response wrong");
  a_cs_drive: assert property ($past(RESET_N) && !$past(SW_STANDBY) && !$past(HW_STANDBY)
    |-> (!P8_PIN_OE[4] || P8_PIN_OUT[4] == $past(CHIP_SELECT_N[0]))
    && (!P8_PIN_OE[1] || P8_PIN_OUT[1] == $past(CHIP_SELECT_N[3]))) else $error("chip select not driven");
  a_sw_hold: assert property (SW_STANDBY && !HW_STANDBY ##1 SW_STANDBY && !HW_STANDBY
    |-> $stable(P8_PIN_OUT) && $stable(P8_PIN_OE)) else $error("pins moved in standby");
  a_hw_reload: assert property (HW_STANDBY [*3] |-> P8_PIN_OE == 5'h10 && P6_PIN_OE == 3'h0)
    else $error("standby reload wrong");
  a_bus_request_in_mode: assert property (!BUS_REQUEST_IN_N |-> !P6_PIN_OE[1] && P6_PIN_OE[2])
    else $error("bus request pin mode wrong");
  a_wait_mode: assert property (!WAIT_IN_N |-> !P6_PIN_OE[0])
    else $error("wait pin driven");
endmodule
`default_nettype wire

/* testbench/mpio_pin_model.sv */
// Pin loads: each wire shows the drive when enabled, else the load
`timescale 1ns/100ps
`default_nettype none
module mpio_pin_model
  import mpio_pkg::*;
(
  input  wire logic [MPIO_P6_W-1:0] p6_out,
  input  wire logic [MPIO_P6_W-1:0] p6_oe,
  input  wire logic [MPIO_P6_W-1:0] p6_load,
  output var  logic [MPIO_P6_W-1:0] p6_wire,
  input  wire logic [MPIO_P8_W-1:0] p8_out,
  input  wire logic [MPIO_P8_W-1:0] p8_oe,
  input  wire logic [MPIO_P8_W-1:0] p8_load,
  output var  logic [MPIO_P8_W-1:0] p8_wire
);
  assign p6_wire = (p6_oe & p6_out) | (~p6_oe & p6_load);
  assign p8_wire = (p8_oe & p8_out) | (~p8_oe & p8_load);
endmodule
`default_nettype wire

/* testbench/mpio_ports_tb_top.sv */
// Testbench top: scenarios for the multiplexed ports
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin errors++; $display("[ERR] t=%0t got=%0h exp=%0h", $time, a, b); end end
module mpio_ports_tb_top
  import mpio_pkg::*;
;
  logic        clk, rst_n, hws, sws, psel, penable, pwrite, pready, pslverr, back, bus_request_in, wait_n, e, rfe, rfs;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [2:0]  p6out, p6oe, p6in, p6_load;
  logic [7:0]  p7in;
  logic [4:0]  p8out, p8oe, p8in, p8_load;
  logic [3:0]  cs, irq_n, pstrb;
  int          errors, n_checks, cyc;
  mpio_ports u_dut (.CORE_CLK(clk), .RESET_N(rst_n), .HW_STANDBY(hws), .SW_STANDBY(sws), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .P6_PIN_IN(p6in), .P6_PIN_OUT(p6out), .P6_PIN_OE(p6oe),
    .P7_PIN_IN(p7in), .P8_PIN_IN(p8in), .P8_PIN_OUT(p8out), .P8_PIN_OE(p8oe), .BUS_ACK_N(back),
    .BUS_REQUEST_IN_N(bus_request_in), .WAIT_IN_N(wait_n), .CHIP_SELECT_N(cs), .REFRESH_STROBE_N(rfs),
    .REFRESH_ENABLE(rfe), .EXT_INTERRUPT_N(irq_n));
  mpio_pin_model u_pins (.p6_out(p6out), .p6_oe(p6oe), .p6_load(p6_load), .p6_wire(p6in),
    .p8_out(p8out), .p8_oe(p8oe), .p8_load(p8_load), .p8_wire(p8in));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic summarize;
    if (errors == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      summarize();
    end
  end
  // ==========================================================
  // APB master
  task automatic apb(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    r = prdata; e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d); apb(1'b1, a, d); endtask
  task automatic rd(input logic [15:0] a); apb(1'b0, a, 8'h00); endtask
  task automatic tick(input int n); repeat (n) @(posedge clk); endtask
  // ==========================================================
  // Scenarios
  task automatic t_reset;
    `CHK(p8oe, 5'h10)
    `CHK(p6oe, 3'h0)
    rd(MPIO_P8_DIR_ADDR); `CHK(r, 32'hFF)
    rd(MPIO_P8_DATA_ADDR); `CHK(r, {24'h0, 4'hE, p8_load[3:0]})
  endtask
  task automatic t_p7;
    logic [7:0] v [2] = '{8'hA5, 8'h5A};
    foreach (v[i]) begin
      p7in <= v[i]; tick(6);
      rd(MPIO_P7_LEVEL_ADDR); `CHK(r, {24'h0, v[i]})
    end
    wr(MPIO_P7_LEVEL_ADDR, 8'h00); rd(MPIO_P7_LEVEL_ADDR); `CHK(r, 32'h5A)
  endtask
  task automatic t_p8;
    cs <= 4'b0101; wr(MPIO_P8_DIR_ADDR, 8'h1F); wr(MPIO_P8_DATA_ADDR, 8'h0B); tick(2);
    `CHK(p8oe, 5'h1F)
    `CHK(p8out, {cs[0], cs[1], cs[2], cs[3], 1'b1})
    rd(MPIO_P8_DATA_ADDR); `CHK(r, 32'hEB)
    pstrb <= 4'h0; wr(MPIO_P8_DATA_ADDR, 8'h00); pstrb <= 4'hF;
    rd(MPIO_P8_DATA_ADDR); `CHK(r, 32'hEB)
    p8_load <= 5'h15; wr(MPIO_P8_DIR_ADDR, 8'h00); tick(6);
    `CHK(p8oe, 5'h00)
    rd(MPIO_P8_DATA_ADDR); `CHK(r, 32'hF5)
    `CHK(irq_n, 4'h5)
  endtask
  task automatic t_sw;
    wr(MPIO_P8_DIR_ADDR, 8'h1F); tick(2); sws <= 1'b1; tick(2); cs <= 4'b1100; tick(3);
    `CHK(p8out, 5'h15)
    sws <= 1'b0; tick(2);
    `CHK(p8out, 5'h07)
    rd(MPIO_P8_DATA_ADDR); `CHK(r, 32'hEB)
  endtask
  task automatic t_hw;
    hws <= 1'b1; tick(3); hws <= 1'b0; tick(2);
    `CHK(p8oe, 5'h10)
    rd(MPIO_P8_DATA_ADDR); `CHK(r, {24'h0, 4'hE, p8_load[3:0]})
    rfe <= 1'b1; rfs <= 1'b0; tick(2);
    `CHK({p8oe[0], p8out[0]}, 2'b10)
    rfe <= 1'b0; rfs <= 1'b1; tick(2);
  endtask
  task automatic t_bus;
    wr(MPIO_P6_DIR_ADDR, 8'h07); wr(MPIO_P6_DATA_ADDR, 8'h07); tick(2);
    `CHK(p6oe, 3'h7)
    p6_load <= 3'h0; back <= 1'b0; wr(MPIO_BUS_CTRL_ADDR, 8'h01); tick(8);
    `CHK(p6oe, 3'h5)
    `CHK({p6out[2], bus_request_in}, 2'b00)
    wr(MPIO_BUS_CTRL_ADDR, 8'h00); tick(6);
    `CHK({p6oe, bus_request_in}, 4'hF)
  endtask
  task automatic t_wait;
    wr(MPIO_WAIT_CTRL_ADDR, 8'h1F); tick(8);
    `CHK({p6oe[0], wait_n}, 2'b00)
    wr(MPIO_WAIT_CTRL_ADDR, 8'h0F); tick(6);
    `CHK({p6oe[0], wait_n}, 2'b11)
    rd(16'hFFD0); `CHK({e, r}, 33'h100000000)
  endtask
  initial begin
    rst_n = 1'b0; hws = 1'b0; sws = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 16'h0000; pwdata = 32'h0; back = 1'b1; cs = 4'hF; p7in = 8'h3C;
    p6_load = 3'h7; p8_load = 5'h0A; errors = 0; n_checks = 0; cyc = 0;
    pstrb = 4'hF; rfe = 1'b0; rfs = 1'b1;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    tick(8);
    t_reset; t_p7; t_p8; t_sw; t_hw; t_bus; t_wait;
    summarize();
  end
endmodule
bind mpio_ports mpio_ports_chk u_chk (.CORE_CLK, .RESET_N, .HW_STANDBY, .SW_STANDBY, .PSEL, .PENABLE, .PWRITE,
  .PADDR, .PRDATA, .PSLVERR, .P6_PIN_OE, .P7_PIN_IN, .P8_PIN_OUT, .P8_PIN_OE, .BUS_REQUEST_IN_N, .WAIT_IN_N,
  .CHIP_SELECT_N);
`default_nettype wire
